// file: verilog/usbif_regs.svh
// register map, field positions, reset values and timing counts of the usb irq flag block
// assumes a 32-bit apb slave with word-aligned registers; index = byte address / 4
`ifndef USBIF_REGS_SVH
`define USBIF_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define USBIF_IDX_POWER      10'h001
`define USBIF_IDX_IN_FLAGS   10'h002
`define USBIF_IDX_OUT_FLAGS  10'h004
`define USBIF_IDX_CMN_FLAGS  10'h006
`define USBIF_IDX_IN_EN      10'h007
`define USBIF_IDX_OUT_EN     10'h009
`define USBIF_IDX_CMN_EN     10'h00b
`define USBIF_IDX_IRQ_STAT   10'h00c
`define USBIF_IDX_IRQ_MASK   10'h00d
`define USBIF_IDX_CPU_EN     10'h00e

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define USBIF_CMN_SOF        3
`define USBIF_CMN_RST        2
`define USBIF_CMN_RSU        1
`define USBIF_CMN_SUS        0
`define USBIF_PWR_SDE        0
`define USBIF_PWR_SUSP       1
`define USBIF_CPU_USB        0

// ----------------------------------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------------------------------
`define USBIF_RST_FLAGS      8'h00
`define USBIF_RST_IN_EN      8'h0f
`define USBIF_RST_OUT_EN     8'h0e
`define USBIF_RST_CMN_EN     8'h06
`define USBIF_RST_IRQ_MASK   3'h7
`define USBIF_MASK_IN        8'h0f
`define USBIF_MASK_OUT       8'h0e
`define USBIF_MASK_CMN       8'h0f

// ----------------------------------------------------------------
// timing: one full speed frame at a 50 ns clock
// ----------------------------------------------------------------
`define USBIF_FRAME_NS       1000000
`define USBIF_CLK_NS         50
`define USBIF_FRAME_CYC      (`USBIF_FRAME_NS / `USBIF_CLK_NS)

`endif

// file: verilog/usbif_pkg.sv
// types shared by the usb irq flag block
// assumes the constants header is included by every user
package usbif_pkg;

  // event pulses from the usb function core, one cycle each
  typedef struct packed {
    logic       control_ep;  // endpoint 0 transaction done
    logic [2:0] in_ep;       // in endpoints 3..1
    logic [2:0] out_ep;      // out endpoints 3..1
    logic       sof_token;   // good sof token seen
    logic       bus_reset;   // reset signalling detected
    logic       resume;      // resume signalling detected
    logic       suspend;     // suspend signalling detected
  } usbif_evt_t;

  // view of the three flag registers
  typedef struct packed {
    logic [7:0] cmn;
    logic [7:0] outp;
    logic [7:0] inp;
  } usbif_flags_t;

endpackage

// file: verilog/usbif_flagreg.sv
// one 8-bit read-to-clear interrupt flag register
// assumes set pulses are synchronous to pclk and clear comes from a completed read
`include "usbif_regs.svh"
module usbif_flagreg import usbif_pkg::*; #(
  parameter logic [7:0] IMPL = 8'hff  // implemented bits, others stay zero
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] set,       // new events this cycle
  input  wire logic       clr,       // read completed this cycle
  input  wire logic [7:0] clr_bits,  // bits that the read returned
  output logic      [7:0] flags
);

  // ----------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------
  logic [7:0] flags_q;  // held flags
  logic [7:0] flags_d;  // next flags

  // only bits handed to software are cleared, so an event that lands
  // between the data capture and the clear edge survives; set wins
  always_comb begin
    flags_d = flags_q;
    if (clr) begin
      flags_d = flags_q & ~clr_bits;
    end
    flags_d = (flags_d | set) & IMPL;
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `USBIF_RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule

// file: verilog/usbif_sof_synth.sv
// start-of-frame event source: passes real tokens unless halted and fills in missed ones
// assumes one frame per FRAME_CYCLES clocks; synthesis starts after the first token
`include "usbif_regs.svh"
module usbif_sof_synth import usbif_pkg::*; #(
  parameter int FRAME_CYCLES = `USBIF_FRAME_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sof_token,  // good token pulse
  input  wire logic halt,       // bus reset or suspend: stop expecting frames
  output logic      sof_evt     // token or synthesized frame pulse
);

  // ----------------------------------------------------------------
  // frame timer
  // ----------------------------------------------------------------
  logic [15:0] cnt_q;    // cycles since last frame start
  logic [15:0] cnt_d;
  logic        armed_q;  // a token was seen, frame timing known
  logic        armed_d;
  logic        synth;    // expected frame time reached without token

  // the timer restarts on every real token, so an early token simply
  // realigns the frame rather than giving two pulses in a row
  always_comb begin
    cnt_d   = cnt_q;
    armed_d = armed_q;
    synth   = 1'b0;
    if (halt) begin
      armed_d = 1'b0;
      cnt_d   = 16'h0000;
    end else if (sof_token) begin
      armed_d = 1'b1;
      cnt_d   = 16'h0000;
    end else if (armed_q) begin
      if (cnt_q == 16'(FRAME_CYCLES - 1)) begin
        synth = 1'b1;
        cnt_d = 16'h0000;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 16'h0000;
      armed_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      armed_q <= armed_d;
    end
  end

  assign sof_evt = (sof_token & ~halt) | synth;

endmodule

// file: verilog/usbif_irq_flags.sv
// top of the usb function interrupt flag block with its apb register file
// assumes event pulses from the usb core are one pclk cycle wide and synchronous
//
// How it works
// - any set flag raises combined request
// - global cpu enable gates request to processor
// - flag registers ignore software writes
// - reading a flag register clears it
// - in flags: control ep bit0, in eps bits1-3
// - out flags: out eps bits1-3, bit0 unused
// - upper four bits read zero
// - sof token sets common bit 3 except in a bus reset cycle or while suspended
// - missed sof synthesized at frame time
// - bus reset sets common bit 2
// - resume sets bit 1 only while suspended
// - suspend sets bit 0 when detection enabled
// - detection disabled: ignore suspend entirely
// - common read after resume ends suspend state
// - every source has its own enable
//
// Chosen here: register access over APB.
`include "usbif_regs.svh"
module usbif_irq_flags import usbif_pkg::*; #(
  parameter int FRAME_CYCLES = `USBIF_FRAME_CYC  // clocks per frame
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  usbif_evt_t       evt,
  output logic             suspend_state,
  output logic             usb_irq_req,
  output logic             cpu_irq
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [9:0] idx;     // word index of the access
  logic       setup;   // setup phase of any transfer
  logic       access;  // completing access phase
  logic       wr;      // completing write
  logic       rd;      // completing read
  logic       hit;     // index is mapped

  assign idx    = paddr[11:2];
  assign setup  = psel & ~penable;
  assign access = psel & penable;  // zero wait states
  assign wr     = access & pwrite;
  assign rd     = access & ~pwrite;

  // mapped indices, one compare each
  always_comb begin
    case (idx)
      `USBIF_IDX_POWER,
      `USBIF_IDX_IN_FLAGS,
      `USBIF_IDX_OUT_FLAGS,
      `USBIF_IDX_CMN_FLAGS,
      `USBIF_IDX_IN_EN,
      `USBIF_IDX_OUT_EN,
      `USBIF_IDX_CMN_EN,
      `USBIF_IDX_IRQ_STAT,
      `USBIF_IDX_IRQ_MASK,
      `USBIF_IDX_CPU_EN: hit = 1'b1;
      default:           hit = 1'b0;  // unmapped answers with an error
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = access & ~hit;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [7:0] in_en_q;     // in endpoint enables
  logic [7:0] in_en_d;
  logic [7:0] out_en_q;    // out endpoint enables
  logic [7:0] out_en_d;
  logic [7:0] cmn_en_q;    // common event enables
  logic [7:0] cmn_en_d;
  logic       sde_q;       // suspend detection enable
  logic       sde_d;
  logic [2:0] mask_q;      // irq status mask, one bit per flag register
  logic [2:0] mask_d;
  logic       cpu_en_q;    // global usb enable toward the processor
  logic       cpu_en_d;
  logic       wr_lane0;    // low byte written

  // only byte lane 0 carries fields; other lanes write nothing
  assign wr_lane0 = wr & pstrb[0];

  // writes to the flag registers are deliberately absent here: those
  // words are read-only; the status word is write-one-to-clear below
  always_comb begin
    in_en_d  = in_en_q;
    out_en_d = out_en_q;
    cmn_en_d = cmn_en_q;
    sde_d    = sde_q;
    mask_d   = mask_q;
    cpu_en_d = cpu_en_q;
    if (wr_lane0) begin
      case (idx)
        `USBIF_IDX_POWER:    sde_d    = pwdata[`USBIF_PWR_SDE];
        `USBIF_IDX_IN_EN:    in_en_d  = pwdata[7:0] & `USBIF_MASK_IN;
        `USBIF_IDX_OUT_EN:   out_en_d = pwdata[7:0] & `USBIF_MASK_OUT;
        `USBIF_IDX_CMN_EN:   cmn_en_d = pwdata[7:0] & `USBIF_MASK_CMN;
        `USBIF_IDX_IRQ_MASK: mask_d   = pwdata[2:0];
        `USBIF_IDX_CPU_EN:   cpu_en_d = pwdata[`USBIF_CPU_USB];
        default:             cpu_en_d = cpu_en_q;  // flag words ignore writes
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_en_q  <= `USBIF_RST_IN_EN;
      out_en_q <= `USBIF_RST_OUT_EN;
      cmn_en_q <= `USBIF_RST_CMN_EN;
      sde_q    <= 1'b0;
      mask_q   <= `USBIF_RST_IRQ_MASK;
      cpu_en_q <= 1'b0;
    end else begin
      in_en_q  <= in_en_d;
      out_en_q <= out_en_d;
      cmn_en_q <= cmn_en_d;
      sde_q    <= sde_d;
      mask_q   <= mask_d;
      cpu_en_q <= cpu_en_d;
    end
  end

  // ----------------------------------------------------------------
  // suspend state and resume tracking
  // ----------------------------------------------------------------
  logic susp_q;       // function is in suspend mode
  logic susp_d;
  logic rsu_seen_q;   // resume detected while suspended, not yet read
  logic rsu_seen_d;
  logic susp_evt;     // accepted suspend detection
  logic rsu_evt;      // accepted resume detection
  logic cmn_rd;       // completed read of the common flags

  assign susp_evt = evt.suspend & sde_q;
  assign rsu_evt  = evt.resume & susp_q;
  assign cmn_rd   = rd & (idx == `USBIF_IDX_CMN_FLAGS);

  // suspend stays in force after resume until software reads the
  // common flags; bus reset ends it at once
  always_comb begin
    susp_d     = susp_q;
    rsu_seen_d = rsu_seen_q;
    if (cmn_rd && rsu_seen_q) begin
      susp_d     = 1'b0;
      rsu_seen_d = 1'b0;
    end
    if (rsu_evt) begin
      rsu_seen_d = 1'b1;  // a new resume wins over the clearing read
    end
    if (susp_evt) begin
      susp_d     = 1'b1;
      rsu_seen_d = 1'b0;  // stale resume must not end a new suspend
    end
    if (evt.bus_reset) begin
      susp_d     = 1'b0;
      rsu_seen_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      susp_q     <= 1'b0;
      rsu_seen_q <= 1'b0;
    end else begin
      susp_q     <= susp_d;
      rsu_seen_q <= rsu_seen_d;
    end
  end

  assign suspend_state = susp_q;

  // ----------------------------------------------------------------
  // event sources into the flag registers
  // ----------------------------------------------------------------
  logic         sof_evt;  // real or synthesized frame start
  logic [7:0]   in_set;   // in flag set pulses
  logic [7:0]   out_set;  // out flag set pulses
  logic [7:0]   cmn_set;  // common flag set pulses
  usbif_flags_t flg;      // current flags
  logic [7:0]   rsnap_q;  // word captured in setup and held; its bits are cleared from the flags at access
  logic [7:0]   rsnap_d;
  logic [2:0]   rclr;     // clearing read per flag register

  usbif_sof_synth #(
    .FRAME_CYCLES (FRAME_CYCLES)
  ) u_sof (
    .pclk      (pclk),
    .presetn   (presetn),
    .sof_token (evt.sof_token),
    .halt      (evt.bus_reset | susp_q),
    .sof_evt   (sof_evt)
  );

  assign in_set  = {4'h0, evt.in_ep, evt.control_ep} & in_en_q;
  assign out_set = {4'h0, evt.out_ep, 1'b0} & out_en_q;

  // common flags gated by their enables and the suspend rules
  always_comb begin
    cmn_set                  = 8'h00;
    cmn_set[`USBIF_CMN_SOF]  = sof_evt;
    cmn_set[`USBIF_CMN_RST]  = evt.bus_reset;
    cmn_set[`USBIF_CMN_RSU]  = rsu_evt;
    cmn_set[`USBIF_CMN_SUS]  = susp_evt;
    cmn_set                  = cmn_set & cmn_en_q;
  end

  assign rclr[0] = rd & (idx == `USBIF_IDX_IN_FLAGS);
  assign rclr[1] = rd & (idx == `USBIF_IDX_OUT_FLAGS);
  assign rclr[2] = cmn_rd;

  usbif_flagreg #(
    .IMPL (`USBIF_MASK_IN)
  ) u_in_flags (
    .pclk     (pclk),
    .presetn  (presetn),
    .set      (in_set),
    .clr      (rclr[0]),
    .clr_bits (rsnap_q),
    .flags    (flg.inp)
  );

  usbif_flagreg #(
    .IMPL (`USBIF_MASK_OUT)
  ) u_out_flags (
    .pclk     (pclk),
    .presetn  (presetn),
    .set      (out_set),
    .clr      (rclr[1]),
    .clr_bits (rsnap_q),
    .flags    (flg.outp)
  );

  usbif_flagreg #(
    .IMPL (`USBIF_MASK_CMN)
  ) u_cmn_flags (
    .pclk     (pclk),
    .presetn  (presetn),
    .set      (cmn_set),
    .clr      (rclr[2]),
    .clr_bits (rsnap_q),
    .flags    (flg.cmn)
  );

  // ----------------------------------------------------------------
  // interrupt status, mask and outputs
  // ----------------------------------------------------------------
  logic [2:0] stat_q;   // sticky: a flag register held a one
  logic [2:0] stat_d;
  logic [2:0] grp_any;  // flag register non-zero

  assign grp_any = {|flg.cmn, |flg.outp, |flg.inp};

  // write one to clear; a group still pending sets again the same edge
  always_comb begin
    stat_d = stat_q;
    if (wr_lane0 && (idx == `USBIF_IDX_IRQ_STAT)) begin
      stat_d = stat_q & ~pwdata[2:0];
    end
    stat_d = stat_d | grp_any;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= stat_d;
    end
  end

  assign usb_irq_req = |grp_any;
  assign cpu_irq     = cpu_en_q & |(stat_q & mask_q);

  // ----------------------------------------------------------------
  // read data, captured in the setup phase
  // ----------------------------------------------------------------
  // capturing in setup keeps prdata a flop; the snapshot also tells the
  // flag registers exactly which bits software has seen
  always_comb begin
    rsnap_d = rsnap_q;
    if (setup && !pwrite) begin
      case (idx)
        `USBIF_IDX_POWER:     rsnap_d = {6'h00, susp_q, sde_q};
        `USBIF_IDX_IN_FLAGS:  rsnap_d = flg.inp;
        `USBIF_IDX_OUT_FLAGS: rsnap_d = flg.outp;
        `USBIF_IDX_CMN_FLAGS: rsnap_d = flg.cmn;
        `USBIF_IDX_IN_EN:     rsnap_d = in_en_q;
        `USBIF_IDX_OUT_EN:    rsnap_d = out_en_q;
        `USBIF_IDX_CMN_EN:    rsnap_d = cmn_en_q;
        `USBIF_IDX_IRQ_STAT:  rsnap_d = {5'h00, stat_q};
        `USBIF_IDX_IRQ_MASK:  rsnap_d = {5'h00, mask_q};
        `USBIF_IDX_CPU_EN:    rsnap_d = {7'h00, cpu_en_q};
        default:              rsnap_d = 8'h00;  // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsnap_q <= 8'h00;
    end else begin
      rsnap_q <= rsnap_d;
    end
  end

  assign prdata = {24'h000000, rsnap_q};

endmodule

// file: test/usbif_host_model.sv
// host side of the usb bus: turns a requested bus event into a one-cycle pulse
// assumes the bench holds each request for exactly one pclk cycle
module usbif_host_model import usbif_pkg::*; (
  input  wire logic pclk,     // function clock
  input  wire logic presetn,  // async reset, active low
  input  usbif_evt_t req,     // event wanted by the bench
  output usbif_evt_t evt      // event seen by the block
);
  // ----------------------------------------------------------------
  // line delay
  // ----------------------------------------------------------------
  // one clock of delay stands for the decoder ahead of the block, so a
  // request never reaches the block in the edge that launched it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt <= '0;  // quiet bus while in reset
    end else begin
      evt <= req;
    end
  end
endmodule

// file: test/usbif_irq_flags_properties.sv
// concurrent checks on the ports of the usb irq flag block
// assumes one pclk domain and the register map of the constants header
`include "usbif_regs.svh"
module usbif_irq_chk import usbif_pkg::*; #(
  parameter int FRAME_CYCLES = 50  // clocks per frame
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input usbif_evt_t       evt,
  input wire logic        suspend_state,
  input wire logic        usb_irq_req,
  input wire logic        cpu_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // helper logic: shadow of the two control bits the checks need
  // ----------------------------------------------------------------
  logic [9:0] idx;       // word index of the access
  logic       wr_acc;    // write that takes effect this edge
  logic       rd_acc;    // read of a flag register, access phase
  logic       cpu_en_q;  // shadow of the global cpu enable
  logic       cpu_en_d;
  logic       sde_q;     // shadow of suspend detection enable
  logic       sde_d;
  assign idx    = paddr[11:2];
  assign wr_acc = psel && penable && pwrite && pstrb[0];
  assign rd_acc = psel && penable && !pwrite && (idx == `USBIF_IDX_IN_FLAGS ||
                  idx == `USBIF_IDX_OUT_FLAGS || idx == `USBIF_IDX_CMN_FLAGS);
  // next shadow values follow software writes only
  always_comb begin
    cpu_en_d = cpu_en_q;
    sde_d    = sde_q;
    if (wr_acc && idx == `USBIF_IDX_CPU_EN) begin
      cpu_en_d = pwdata[0];
    end
    if (wr_acc && idx == `USBIF_IDX_POWER) begin
      sde_d = pwdata[0];
    end
  end
  // shadows reset like the real registers, else first checks misfire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_en_q <= 1'b0;
      sde_q    <= 1'b0;
    end else begin
      cpu_en_q <= cpu_en_d;
      sde_q    <= sde_d;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence flag_read_s;
    rd_acc;
  endsequence
  sequence suspend_seen_s;
    evt.suspend && sde_q && !evt.bus_reset;
  endsequence
  irq_set_a: assert property (evt.control_ep |=> usb_irq_req)
    else $error("endpoint event did not raise the request");
  cpu_gate_a: assert property (cpu_irq |-> cpu_en_q)
    else $error("cpu request without global enable");
  flag_hold_a: assert property ($fell(usb_irq_req) |-> $past(rd_acc))
    else $error("request dropped without a flag read");
  upper_zero_a: assert property (flag_read_s |-> prdata[31:4] == 28'h0)
    else $error("unused flag bits read nonzero");
  out_bit0_a: assert property (flag_read_s and idx == `USBIF_IDX_OUT_FLAGS |-> !prdata[0])
    else $error("unused out bit 0 read nonzero");
  susp_enter_a: assert property (suspend_seen_s |=> suspend_state)
    else $error("suspend not entered");
  susp_only_a: assert property ($rose(suspend_state) |-> $past(evt.suspend && sde_q))
    else $error("suspend entered without enabled detection");
  susp_exit_a: assert property ($fell(suspend_state) |->
      $past(evt.bus_reset || (rd_acc && idx == `USBIF_IDX_CMN_FLAGS)))
    else $error("suspend left without reset or common read");
  ready_now_a: assert property (psel && penable |-> pready)
    else $error("access not completed at once");
endmodule

bind usbif_irq_flags usbif_irq_chk #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .evt(evt), .suspend_state(suspend_state),
  .usb_irq_req(usb_irq_req), .cpu_irq(cpu_irq));

// file: test/usbif_irq_flags_tb.sv
// self-checking bench for the usb irq flag block against a flag model
// assumes a 20 MHz pclk and the apb map of the constants header
`include "usbif_regs.svh"
module usbif_irq_flags_tb import usbif_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FC = 50;  // short frame keeps the run brief
  localparam logic [9:0] RI [9] = '{`USBIF_IDX_IN_FLAGS, `USBIF_IDX_OUT_FLAGS,
    `USBIF_IDX_CMN_FLAGS, `USBIF_IDX_IN_EN, `USBIF_IDX_OUT_EN, `USBIF_IDX_CMN_EN,
    `USBIF_IDX_IRQ_MASK, `USBIF_IDX_POWER, `USBIF_IDX_CPU_EN};
  localparam logic [7:0] RV [9] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h0e, 8'h06, 8'h07,
    8'h00, 8'h00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, rng;
  logic [3:0]  pstrb;
  logic        suspend_state, usb_irq_req, cpu_irq;
  usbif_evt_t  req, evt;
  logic [7:0]  fl [3];                 // model flags: in, out, common
  logic [7:0]  in_en, out_en, cmn_en;  // model enables
  bit          sde, susp, rsu;         // model suspend control
  int          fails, samples_checked;
  usbif_host_model host (.pclk(pclk), .presetn(presetn), .req(req), .evt(evt));
  usbif_irq_flags #(.FRAME_CYCLES(FC)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .suspend_state(suspend_state), .usb_irq_req(usb_irq_req), .cpu_irq(cpu_irq));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [9:0] fi(int g);
    return g == 0 ? `USBIF_IDX_IN_FLAGS : g == 1 ? `USBIF_IDX_OUT_FLAGS : `USBIF_IDX_CMN_FLAGS;
  endfunction
  // model reaction to one event pulse
  function automatic void apply(usbif_evt_t e);
    fl[0] |= {4'h0, e.in_ep, e.control_ep} & in_en;
    fl[1] |= {4'h0, e.out_ep, 1'b0} & out_en;
    fl[2] |= {4'h0, e.sof_token, e.bus_reset, e.resume & susp, e.suspend & sde} & cmn_en;
    if (e.resume && susp) rsu = 1'b1;
    if (e.suspend && sde) {susp, rsu} = 2'b10;
    if (e.bus_reset) susp = 1'b0;
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one apb transfer; ev is put on the bus so it lands in the access cycle
  task automatic apb(bit w, logic [9:0] i, logic [7:0] d, usbif_evt_t ev = '0);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    req <= ev;
    @(posedge pclk);
    penable <= 1'b1;
    req <= '0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      stop_test();
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(logic [9:0] i, logic [7:0] d);
    apb(1'b1, i, d);
  endtask
  // read a flag group, compare, then clear what was returned
  task automatic rdf(int g, usbif_evt_t ev = '0);
    logic [7:0] e;
    e = fl[g];
    apb(1'b0, fi(g), 8'h00, ev);
    chk("flags", rdv, {24'h0, e});
    fl[g] = fl[g] & ~e;
    if (g == 2 && rsu) begin
      susp = 1'b0;
      rsu = 1'b0;
    end
    apply(ev);
    chk("suspend", suspend_state, susp);
  endtask
  task automatic fire(usbif_evt_t ev);
    req <= ev;
    @(posedge pclk);
    req <= '0;
    repeat (2) @(posedge pclk);
    apply(ev);
    @(negedge pclk);
    chk("irq", usb_irq_req, |{fl[0], fl[1], fl[2]});
    chk("suspend", suspend_state, susp);
    @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, req, fails, samples_checked} = '0;
    {presetn, sde, susp, rsu} = '0;
    pstrb = 4'hf;
    rng = 32'hf54f87f9;
    fl = '{default: 8'h00};
    {in_en, out_en, cmn_en} = {8'h0f, 8'h0e, 8'h06};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 9; k++) begin
      apb(1'b0, RI[k], 8'h00);
      chk("reset", rdv, {24'h0, RV[k]});
    end
    apb(1'b0, 10'h3ff, 8'h00);
    chk("unmapped error", err, 1);
    chk("unmapped data", rdv, 0);
    pstrb <= 4'he;
    wr(`USBIF_IDX_CPU_EN, 8'h01);
    pstrb <= 4'hf;
    apb(1'b0, `USBIF_IDX_CPU_EN, 8'h00);
    chk("strobe", rdv, 32'h0);
    $display("test reset done");
    // random endpoint traffic; flag writes in between must not disturb
    for (int k = 0; k < 6; k++) begin
      rng = xs(rng);
      fire({rng[6:0], 4'h0});
      wr(fi(k % 3), rng[15:8]);
      rdf(0);
      rdf(1);
    end
    rdf(0);
    rdf(1);
    $display("test endpoints done");
    wr(`USBIF_IDX_IN_EN, 8'hf7);
    in_en = 8'h07;
    apb(1'b0, `USBIF_IDX_IN_EN, 8'h00);
    chk("in enable", rdv, 32'h7);
    fire(11'h380);
    rdf(0);
    wr(`USBIF_IDX_IN_EN, 8'h0f);
    in_en = 8'h0f;
    fire(11'h080);
    rdf(0, 11'h400);
    rdf(0);
    $display("test enables done");
    wr(`USBIF_IDX_CMN_EN, 8'h0f);
    cmn_en = 8'h0f;
    fire(11'h001);
    fire(11'h002);
    rdf(2);
    wr(`USBIF_IDX_POWER, 8'h01);
    sde = 1'b1;
    fire(11'h001);
    fire(11'h002);
    rdf(2);
    fire(11'h004);
    rdf(2);
    $display("test common done");
    fire(11'h008);
    rdf(2);
    repeat (FC + 5) @(posedge pclk);
    fl[2][3] = 1'b1;
    rdf(2);
    fire(11'h004);
    rdf(2);
    repeat (FC + 5) @(posedge pclk);
    rdf(2);
    $display("test frames done");
    wr(`USBIF_IDX_IRQ_STAT, 8'h07);
    wr(`USBIF_IDX_CPU_EN, 8'h01);
    chk("cpu irq", cpu_irq, 0);
    fire(11'h400);
    chk("cpu irq", cpu_irq, 1);
    apb(1'b0, `USBIF_IDX_IRQ_STAT, 8'h00);
    chk("status", rdv, 32'h1);
    wr(`USBIF_IDX_IRQ_MASK, 8'h00);
    chk("cpu irq", cpu_irq, 0);
    wr(`USBIF_IDX_IRQ_MASK, 8'h07);
    chk("cpu irq", cpu_irq, 1);
    wr(`USBIF_IDX_CPU_EN, 8'h00);
    chk("cpu irq", cpu_irq, 0);
    wr(`USBIF_IDX_CPU_EN, 8'h01);
    rdf(0);
    wr(`USBIF_IDX_IRQ_STAT, 8'h01);
    chk("cpu irq", {cpu_irq, usb_irq_req}, 0);
    $display("test interrupts done");
    stop_test();
  end
endmodule
